// *** pkg/conv_ctrl_pkg.sv ***
package conv_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] status_control_off = 8'h00;
	localparam logic [7:0] control2_off       = 8'h04;
	localparam logic [7:0] compare_value_off  = 8'h08;
	localparam logic [7:0] result_off         = 8'h0c;
	localparam logic [7:0] irq_status_off     = 8'h10;
	localparam logic [7:0] irq_mask_off       = 8'h14;
	// status/control field positions
	localparam int complete_flag_bit = 7;
	localparam int irq_enable_bit    = 6;
	localparam int cont_bit     = 5;
	localparam int chan_msb     = 4;
	// control2 field positions
	localparam int active_bit   = 7;
	localparam int trig_bit     = 6;
	localparam int cmp_en_bit   = 5;
	localparam int cmp_gt_bit   = 4;
	// channel codes
	localparam logic [4:0] chan_last_input = 5'h1b;
	localparam logic [4:0] chan_reserved   = 5'h1c;
	localparam logic [4:0] chan_ref_high   = 5'h1d;
	localparam logic [4:0] chan_ref_low    = 5'h1e;
	localparam logic [4:0] chan_off        = 5'h1f;
	// reset values
	localparam logic [7:0] status_control_rst = 8'h1f;
	localparam logic [7:0] control2_rst       = 8'h00;
	// conversion time
	localparam int conv_time_ns   = 100;
	localparam int clock_ns       = 4;
	localparam int conv_cycles    = (conv_time_ns + clock_ns - 1) / clock_ns;
	// interrupt status bits
	localparam int irq_done_bit   = 0;
	localparam int irq_abort_bit  = 1;
	// axi answers
	localparam logic [1:0] resp_okay   = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// *** rtl/conv_control.sv ***
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// RULE1 - any status/control write aborts; it restarts in software mode only, and not when channel is all ones
// RULE2 - complete flag bit 7 is read-only to software
// RULE3 - compare off: flag set at end of every conversion
// RULE4 - compare on: flag set only when compare condition true
// RULE5 - flag cleared by status/control write or low result read
// RULE6 - flag setting with enable bit 6 raises the interrupt
// RULE7 - continuous off: one conversion per write or per hardware trigger
// RULE8 - continuous on: repeat, started by write or hardware trigger
// RULE9 - channel select field is bits 4:0
// RULE10 - codes 0..27 inputs, 28 reserved, 29 high ref, 30 low ref
// RULE11 - all-ones channel powers converter off and isolates input
// RULE12 - all-ones write ends continuous mode without extra conversion
// RULE13 - single mode drops to low power after each conversion
// RULE14 - hardware mode starts on trigger, software mode on write
// RULE15 - active bit held from start until complete or abort
// RULE16 - result updated per conversion unless compare fails
// RULE17 - complete interrupt held as level while flag and enable set
// RULE18 - hardware trigger is rising edge, one conversion per event
module conv_control
	import conv_ctrl_pkg::*;
#(
	parameter int data_bits = 10
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	// axi4-lite write address
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// axi4-lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// analog side
	input  wire logic                 hw_trigger_in,
	input  wire logic [data_bits-1:0] sample_data,
	output logic [4:0]                mux_select,
	output logic                      mux_connect,
	output logic                      converter_power,
	output logic                      input_reserved,
	// interrupts
	output logic                      complete_irq,
	output logic                      irq
);
	// register state
	logic [4:0]           channel_select;
	logic                 complete_irq_enable;
	logic                 continuous_enable;
	logic                 conversion_complete_flag;
	logic                 trigger_select;
	logic                 compare_enable;
	logic                 compare_greater;
	logic [data_bits-1:0] compare_value;
	logic [data_bits-1:0] result_low_reg;
	logic [1:0]           irq_status;
	logic [1:0]           irq_mask;
	logic                 armed;
	logic                 trig_prev;

	// bus slave state
	logic                 aw_held;
	logic                 w_held;
	logic [7:0]           aw_addr;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;

	// conversion handshake
	logic                 start_conv;
	logic                 abort_conv;
	logic                 busy;
	logic                 done;
	logic                 trig_event;
	logic                 compare_true;
	logic                 conv_ok;
	logic                 sc_write;
	logic                 wr_fire;
	logic                 rd_fire;
	logic                 low_read;

	typedef enum logic [1:0] {conv_idle, conv_run} conv_state_e;
	conv_state_e          conv_state;

	// write channels accept independently, response after both
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign sc_write      = wr_fire && aw_addr == status_control_off && w_strb[0];
	assign low_read      = rd_fire && s_axi_araddr == result_off;

	// capture write address and data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == status_control_off || aw_addr == control2_off ||
				aw_addr == compare_value_off || aw_addr == irq_status_off ||
				aw_addr == irq_mask_off || aw_addr == result_off) begin
				s_axi_bresp <= resp_okay;
			end else begin
				s_axi_bresp <= resp_slverr;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// status/control fields; complete flag not writable
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			channel_select      <= status_control_rst[chan_msb:0];
			complete_irq_enable <= status_control_rst[irq_enable_bit];
			continuous_enable   <= status_control_rst[cont_bit];
		end else if (sc_write) begin // RULE2
			channel_select      <= w_data[chan_msb:0]; // RULE9
			complete_irq_enable <= w_data[irq_enable_bit];
			continuous_enable   <= w_data[cont_bit];
		end
	end

	// second control register and compare value
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			trigger_select  <= control2_rst[trig_bit];
			compare_enable  <= control2_rst[cmp_en_bit];
			compare_greater <= control2_rst[cmp_gt_bit];
			compare_value   <= '0;
		end else if (wr_fire) begin
			if (aw_addr == control2_off && w_strb[0]) begin
				trigger_select  <= w_data[trig_bit];
				compare_enable  <= w_data[cmp_en_bit];
				compare_greater <= w_data[cmp_gt_bit];
			end else if (aw_addr == compare_value_off && w_strb[0]) begin
				compare_value <= w_data[data_bits-1:0];
			end
		end
	end

	// hardware trigger rising edge
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= hw_trigger_in;
		end
	end
	assign trig_event = hw_trigger_in && !trig_prev; // RULE18

	// armed: a write enabled conversions, hardware mode awaits trigger
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			armed <= 1'b0;
		end else if (sc_write) begin
			armed <= w_data[chan_msb:0] != chan_off; // RULE12
		end else if (done && !continuous_enable && !trigger_select) begin
			armed <= 1'b0; // RULE7 hardware single mode stays armed per edge
		end
	end

	// start decision
	always_comb begin
		start_conv = 1'b0;
		abort_conv = sc_write && busy; // RULE1
		if (sc_write) begin
			// hardware mode only arms here; the trigger edge starts
			if (w_data[chan_msb:0] != chan_off && !trigger_select) begin
				start_conv = 1'b1; // RULE1 RULE14
			end
		end else if (trigger_select && armed && trig_event && !busy) begin
			start_conv = 1'b1; // RULE14 RULE7
		end else if (done && continuous_enable && armed && channel_select != chan_off) begin
			start_conv = 1'b1; // RULE8
		end
	end

	conv_timer u_timer (
		.clock   (clock),
		.sys_rst (sys_rst),
		.start   (start_conv),
		.stop    (abort_conv),
		.busy    (busy),
		.done    (done)
	);

	// state tracks active conversion
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			conv_state <= conv_idle;
		end else begin
			case (conv_state)
				conv_idle: if (start_conv) conv_state <= conv_run;
				conv_run: if (abort_conv && !start_conv) conv_state <= conv_idle;
					else if (done && !start_conv) conv_state <= conv_idle;
				default: conv_state <= conv_idle;
			endcase
		end
	end

	// compare condition
	assign compare_true = compare_greater ? (sample_data >= compare_value) : (sample_data < compare_value);
	assign conv_ok      = done && (!compare_enable || compare_true); // RULE3 RULE4

	// result register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			result_low_reg <= '0;
		end else if (conv_ok) begin
			result_low_reg <= sample_data; // RULE16
		end
	end

	// complete flag: set wins over clear
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			conversion_complete_flag <= 1'b0;
		end else if (conv_ok) begin
			conversion_complete_flag <= 1'b1; // RULE3 RULE4
		end else if (sc_write || low_read) begin
			conversion_complete_flag <= 1'b0; // RULE5
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status <= 2'h0;
			irq_mask   <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == irq_done_bit && conv_ok) || (i == irq_abort_bit && abort_conv)) begin
					irq_status[i] <= 1'b1;
				end else if (wr_fire && aw_addr == irq_status_off && w_strb[0] && w_data[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
			if (wr_fire && aw_addr == irq_mask_off && w_strb[0]) begin
				irq_mask <= w_data[1:0];
			end
		end
	end

	assign complete_irq = conversion_complete_flag && complete_irq_enable; // RULE6 RULE17
	assign irq          = |(irq_status & irq_mask);

	// analog controls
	assign converter_power = busy; // RULE13 RULE11
	assign mux_connect     = busy && channel_select != chan_off && channel_select != chan_reserved; // RULE11
	assign mux_select      = channel_select; // RULE10
	assign input_reserved  = channel_select == chan_reserved; // RULE10

	// read data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= resp_okay;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= resp_okay;
			s_axi_rdata  <= 32'h0000_0000;
			if (s_axi_araddr == status_control_off) begin
				s_axi_rdata[7:0] <= {conversion_complete_flag, complete_irq_enable, continuous_enable, channel_select};
			end else if (s_axi_araddr == control2_off) begin
				s_axi_rdata[7:0] <= {conv_state == conv_run, trigger_select, compare_enable, compare_greater, 4'h0}; // RULE15
			end else if (s_axi_araddr == compare_value_off) begin
				s_axi_rdata[data_bits-1:0] <= compare_value;
			end else if (s_axi_araddr == result_off) begin
				s_axi_rdata[data_bits-1:0] <= result_low_reg;
			end else if (s_axi_araddr == irq_status_off) begin
				s_axi_rdata[1:0] <= irq_status;
			end else if (s_axi_araddr == irq_mask_off) begin
				s_axi_rdata[1:0] <= irq_mask;
			end else begin
				s_axi_rresp <= resp_slverr;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// *** rtl/conv_timer.sv ***
`timescale 1ns/1ns
// counts one conversion; restart aborts and reloads
module conv_timer
	import conv_ctrl_pkg::*;
#(
	parameter int cycles = conv_cycles
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// control
	input  wire logic start,
	input  wire logic stop,
	// status
	output logic      busy,
	output logic      done
);
	localparam int cw = $clog2(cycles + 1);
	logic [cw-1:0] count;

	// down counter, done pulses as busy drops after last cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= cw'(cycles - 1);
				busy  <= 1'b1;
			end else if (stop) begin
				busy <= 1'b0;
			end else if (busy) begin
				if (count == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule

// *** verification/conv_control_checker.sv ***
`timescale 1ns/1ns
// watchers on the top ports
module conv_control_checker
	import conv_ctrl_pkg::*;
#(
	parameter int data_bits = 10
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// converter side
	input wire logic        hw_trigger_in,
	input wire logic [4:0]  mux_select,
	input wire logic        mux_connect,
	input wire logic        converter_power,
	input wire logic        input_reserved,
	input wire logic        complete_irq
);
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic        trig_hw;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// last write address, data and trigger mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			aw_q <= 8'h00;
			w_q <= 32'h0;
			trig_hw <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
			if ($rose(s_axi_bvalid) && aw_q == control2_off) trig_hw <= w_q[trig_bit];
		end
	end
	hold_b_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	hold_r_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	resv_flag_a: assert property (input_reserved == (mux_select == chan_reserved))
		else $error("reserved flag wrong");
	connect_gate_a: assert property (mux_connect |-> converter_power && mux_select != chan_off)
		else $error("input connected while off");
	off_write_a: assert property ($rose(s_axi_bvalid) && aw_q == status_control_off
		&& w_q[4:0] == chan_off |=> !converter_power [*8]) else $error("converter ran after off write");
	sw_start_a: assert property ($rose(s_axi_bvalid) && aw_q == status_control_off
		&& w_q[4:0] != chan_off && !trig_hw |-> ##[0:2] converter_power) else $error("write did not start");
	irq_src_a: assert property ($rose(complete_irq) |-> $past(converter_power, 2))
		else $error("interrupt without conversion");
	hw_start_a: assert property ($rose(hw_trigger_in) && trig_hw && mux_select != chan_off
		|-> ##[1:3] converter_power) else $error("trigger did not start");
	irq_level_a: assert property (complete_irq && !(s_axi_awvalid || s_axi_arvalid || s_axi_rvalid
		|| s_axi_bvalid) && !$past(s_axi_awvalid) && !$past(s_axi_wvalid) |=> complete_irq)
		else $error("interrupt dropped");
	cover property ($rose(complete_irq));
	cover property ($fell(converter_power));
	cover property ($rose(hw_trigger_in) && trig_hw);
endmodule
bind conv_control conv_control_checker #(.data_bits(data_bits)) i_conv_control_checker (.*);

// *** verification/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb
	import conv_ctrl_pkg::*;
;
	logic        clock, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        hw_trigger_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        mux_connect, converter_power, input_reserved, complete_irq, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [1:0]  wr_resp;
	logic [9:0]  sample_data, smp;
	logic [4:0]  mux_select;
	logic [33:0] exp_q[$];
	int          err_total, n_tests;
	conv_control i_conv_control (.*);
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	task print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				wr_resp = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		if (i == 50) begin err_total++; print_verdict(); end
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int i;
		@(posedge clock);
		exp_q.push_back(e);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 50) begin err_total++; print_verdict(); end
	endtask
	task automatic waitp(input logic v);
		int i;
		for (i = 0; i < 200 && converter_power !== v; i++) @(posedge clock);
		if (i == 200) begin err_total++; print_verdict(); end
	endtask
	// wait for one conversion to run and settle
	task conv();
		waitp(1'b1);
		waitp(1'b0);
		repeat (2) @(posedge clock);
	endtask
	task endt(input int id);
		$display("test %0d done", id);
	endtask
	// read answers against the oldest note
	always @(posedge clock) begin
		if (s_axi_rvalid && s_axi_rready)
			`CHK({s_axi_rresp, s_axi_rresp[1] ? 32'h0 : s_axi_rdata}, exp_q.pop_front())
	end
	// main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hw_trigger_in} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_data} = '0;
		s_axi_wstrb = 4'hf;
		sys_rst = 1'b1;
		void'($urandom(32'h2c0c));
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		`CHK(mux_select, chan_off)
		rd(status_control_off, 34'h1f);
		endt(1);
		smp = 10'($urandom);
		sample_data <= smp;
		wr(irq_mask_off, 32'h1);
		wr(status_control_off, 32'h43);
		waitp(1'b1);
		`CHK(mux_connect, 1'b1)
		rd(control2_off, 34'h80);
		conv();
		`CHK(complete_irq, 1'b1)
		`CHK(irq, 1'b1)
		`CHK(converter_power, 1'b0)
		rd(status_control_off, 34'hc3);
		rd(result_off, {24'h0, smp});
		@(posedge clock);
		`CHK(complete_irq, 1'b0)
		rd(status_control_off, 34'h43);
		wr(status_control_off, 32'h83);
		rd(status_control_off, 34'h03);
		conv();
		`CHK(complete_irq, 1'b0)
		rd(status_control_off, 34'h83);
		endt(2);
		wr(irq_status_off, 32'h3);
		wr(status_control_off, 32'h3);
		repeat (5) @(posedge clock);
		wr(status_control_off, 32'h3);
		conv();
		rd(irq_status_off, 34'h3);
		`CHK(irq, 1'b1)
		wr(irq_mask_off, 32'h0);
		@(posedge clock);
		`CHK(irq, 1'b0)
		wr(irq_status_off, 32'h3);
		rd(irq_status_off, 34'h0);
		endt(3);
		wr(compare_value_off, 32'h200);
		wr(control2_off, 32'h20);
		sample_data <= 10'h3ff;
		wr(status_control_off, 32'h2);
		conv();
		rd(status_control_off, 34'h02);
		rd(result_off, {24'h0, smp});
		smp = 10'($urandom % 512);
		sample_data <= smp;
		wr(status_control_off, 32'h2);
		conv();
		rd(status_control_off, 34'h82);
		rd(result_off, {24'h0, smp});
		wr(control2_off, 32'h0);
		endt(4);
		wr(status_control_off, 32'h23);
		repeat (70) @(posedge clock);
		rd(status_control_off, 34'ha3);
		rd(result_off, {24'h0, smp});
		repeat (40) @(posedge clock);
		rd(status_control_off, 34'ha3);
		wr(status_control_off, 32'h1f);
		repeat (40) @(posedge clock);
		`CHK(converter_power, 1'b0)
		rd(status_control_off, 34'h1f);
		endt(5);
		wr(control2_off, 32'h40);
		wr(status_control_off, 32'h3);
		repeat (10) @(posedge clock);
		`CHK(converter_power, 1'b0)
		hw_trigger_in <= 1'b1;
		conv();
		hw_trigger_in <= 1'b0;
		repeat (30) @(posedge clock);
		`CHK(converter_power, 1'b0)
		hw_trigger_in <= 1'b1;
		conv();
		hw_trigger_in <= 1'b0;
		rd(status_control_off, 34'h83);
		wr(control2_off, 32'h0);
		endt(6);
		for (int c = 27; c < 31; c++) begin
			wr(status_control_off, 32'(c));
			`CHK(mux_select, 5'(c))
			`CHK(input_reserved, 1'(5'(c) == chan_reserved))
			`CHK(mux_connect, 1'(5'(c) != chan_reserved))
		end
		wr(status_control_off, 32'h1f);
		`CHK(mux_connect, 1'b0)
		`CHK(wr_resp, resp_okay)
		rd(8'h20, {resp_slverr, 32'h0});
		wr(8'h20, 32'h0);
		`CHK(wr_resp, resp_slverr)
		endt(7);
		repeat (2) @(posedge clock);
		print_verdict();
	end
endmodule
